/* File: bench/lsbd_cache_model.sv */
// Instruction cache stand-in presenting a fetch result every cycle.
`timescale 1ns/1ps
module lsbd_cache_model (
    input wire logic CLOCK, // Clock.
    output logic [31:0] ICACHE_DATA // Cache result.
);
    // A result that changes each cycle shows whether SRAM data wins.
    initial ICACHE_DATA = 32'h5a5a5a5a;
    always @(posedge CLOCK) ICACHE_DATA <= ~ICACHE_DATA;
endmodule

/* File: bench/lsbd_props.sv */
// Port checker for the local SRAM decode, bound to its top module.
`timescale 1ns/1ps
module lsbd_props (
    input wire logic CLOCK, // Clock.
    input wire logic NRST, // Reset, active low.
    input wire logic REQ, WRITE, CREG_RD, DEBUG_STATE, // Requests.
    input wire logic [2:0] SPACE, // Address space.
    input wire logic RESP_DONE, RESP_EXT, RESP_ERR, // Responses.
    input wire logic CACHE_FILL_INH, // Cache inhibit.
    input wire logic [31:0] CREG_RDATA // Register read data.
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    sequence s_rd;
        REQ && !WRITE;
    endsequence
    sequence s_wr;
        REQ && WRITE;
    endsequence
    chk_one_resp: assert property (
        REQ |=> $onehot({RESP_DONE, RESP_EXT, RESP_ERR}))
        else $error("not one response per request");
    chk_idle_quiet: assert property (
        !REQ |=> !(RESP_DONE || RESP_EXT || RESP_ERR))
        else $error("response without request");
    chk_fill_inh: assert property (
        s_rd |=> CACHE_FILL_INH == RESP_DONE)
        else $error("cache inhibit wrong on read");
    chk_wr_nofill: assert property (
        s_wr ##1 1'b1 |-> !CACHE_FILL_INH)
        else $error("cache inhibit on write");
    chk_rd_noerr: assert property (
        s_rd |=> !RESP_ERR)
        else $error("access error on read");
    chk_creg_idle: assert property (
        !CREG_RD |=> CREG_RDATA == 32'h00000000)
        else $error("register data without read");
    chk_user_read: assert property (
        CREG_RD && !DEBUG_STATE |=> CREG_RDATA == 32'h00000000)
        else $error("register readable outside debug");
    chk_rsv_zero: assert property (
        CREG_RD |=> CREG_RDATA[7:6] == 2'h0)
        else $error("reserved bits not zero");
    chk_high_space: assert property (
        REQ && SPACE > 3'h4 |=> RESP_EXT)
        else $error("unknown space not external");
endmodule
bind lsbd_top lsbd_props u_lsbd_props (.CLOCK(CLOCK), .NRST(NRST),
    .REQ(REQ), .WRITE(WRITE), .CREG_RD(CREG_RD), .SPACE(SPACE),
    .DEBUG_STATE(DEBUG_STATE), .RESP_DONE(RESP_DONE), .RESP_EXT(RESP_EXT),
    .RESP_ERR(RESP_ERR), .CACHE_FILL_INH(CACHE_FILL_INH),
    .CREG_RDATA(CREG_RDATA));

/* File: bench/lsbd_top_tb.sv */
// Self-checking bench for the local SRAM decode.
`timescale 1ns/1ps
module lsbd_top_tb;
    logic CLOCK, NRST, REQ, WRITE, CREG_WR, CREG_RD, SUPERVISOR, DEBUG_STATE;
    logic [31:0] ADDR, WDATA, CREG_WDATA, ICACHE_DATA, CREG_RDATA, RDATA;
    logic [11:0] CREG_CODE;
    logic [2:0] SPACE;
    logic [1:0] SIZE;
    logic RESP_DONE, RESP_EXT, RESP_ERR, CACHE_FILL_INH;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    typedef struct {logic w; logic [1:0] sz; logic [2:0] sp;
        logic [31:0] a, d; logic [2:0] r; logic [31:0] q;} lsbd_row_t;
    lsbd_row_t rows [8] = '{
        '{1'b1, 2'h0, 3'h2, 32'h20000000, 32'h11223344, 3'h1, 32'h0},
        '{1'b0, 2'h0, 3'h0, 32'h20000000, 32'h0, 3'h1, 32'h11223344},
        '{1'b1, 2'h0, 3'h0, 32'h20000004, 32'h0, 3'h1, 32'h0},
        '{1'b1, 2'h1, 3'h2, 32'h20000005, 32'h00aa0000, 3'h1, 32'h0},
        '{1'b1, 2'h2, 3'h2, 32'h20000006, 32'h0000beef, 3'h1, 32'h0},
        '{1'b0, 2'h0, 3'h3, 32'h20000004, 32'h0, 3'h1, 32'h00aabeef},
        '{1'b0, 2'h0, 3'h2, 32'h20000200, 32'h0, 3'h2, 32'h0},
        '{1'b0, 2'h0, 3'h5, 32'h20000000, 32'h0, 3'h2, 32'h0}};
    lsbd_top u_lsbd_top (.CLOCK(CLOCK), .NRST(NRST), .REQ(REQ), .ADDR(ADDR),
        .WRITE(WRITE), .SIZE(SIZE), .SPACE(SPACE), .WDATA(WDATA),
        .CREG_WR(CREG_WR), .CREG_RD(CREG_RD), .CREG_CODE(CREG_CODE),
        .CREG_WDATA(CREG_WDATA), .SUPERVISOR(SUPERVISOR),
        .DEBUG_STATE(DEBUG_STATE), .ICACHE_DATA(ICACHE_DATA),
        .CREG_RDATA(CREG_RDATA), .RESP_DONE(RESP_DONE), .RESP_EXT(RESP_EXT),
        .RESP_ERR(RESP_ERR), .RDATA(RDATA), .CACHE_FILL_INH(CACHE_FILL_INH));
    lsbd_cache_model u_lsbd_cache_model (.CLOCK(CLOCK),
        .ICACHE_DATA(ICACHE_DATA));
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            final_report();
        end
    end
    task automatic chk_resp(input logic [2:0] e);
        check_count++;
        if ({RESP_ERR, RESP_EXT, RESP_DONE} !== e) begin
            mismatches++;
            $display("MISMATCH %0t response %b expected %b", $time,
                {RESP_ERR, RESP_EXT, RESP_DONE}, e);
        end
    endtask
    task automatic chk_word(input logic [31:0] g, e);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %0t word %h expected %h", $time, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] sz,
        input logic [2:0] sp, input logic [31:0] a, d);
        @(posedge CLOCK);
        REQ <= 1'b1;
        WRITE <= w;
        SIZE <= sz;
        SPACE <= sp;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLOCK);
        REQ <= 1'b0;
        #1;
    endtask
    task automatic creg(input logic wr, sup, dbg, input logic [11:0] c,
        input logic [31:0] d);
        @(posedge CLOCK);
        CREG_WR <= wr;
        CREG_RD <= !wr;
        SUPERVISOR <= sup;
        DEBUG_STATE <= dbg;
        CREG_CODE <= c;
        CREG_WDATA <= d;
        @(posedge CLOCK);
        CREG_WR <= 1'b0;
        CREG_RD <= 1'b0;
        #1;
    endtask
    initial begin
        {REQ, WRITE, CREG_WR, CREG_RD, SUPERVISOR, DEBUG_STATE} = 6'h00;
        {ADDR, WDATA, CREG_WDATA} = '0;
        {CREG_CODE, SPACE, SIZE} = 17'h00000;
        NRST = 1'b0;
        repeat (20) @(posedge CLOCK);
        NRST <= 1'b1;
        #1;
        chk_resp(3'h0);
        acc(1'b0, 2'h0, 3'h2, 32'h20000000, 32'h0);
        chk_resp(3'h2);
        creg(1'b1, 1'b0, 1'b0, 12'hc04, 32'h20000001);
        acc(1'b0, 2'h0, 3'h2, 32'h20000000, 32'h0);
        chk_resp(3'h2);
        creg(1'b1, 1'b1, 1'b0, 12'hc05, 32'h20000001);
        acc(1'b0, 2'h0, 3'h2, 32'h20000000, 32'h0);
        chk_resp(3'h2);
        creg(1'b1, 1'b0, 1'b1, 12'hc04, 32'h200000c1);
        creg(1'b0, 1'b0, 1'b1, 12'hc04, 32'h0);
        chk_word(CREG_RDATA, 32'h20000001);
        creg(1'b0, 1'b1, 1'b0, 12'hc04, 32'h0);
        chk_word(CREG_RDATA, 32'h0);
        foreach (rows[i]) begin
            acc(rows[i].w, rows[i].sz, rows[i].sp, rows[i].a, rows[i].d);
            chk_resp(rows[i].r);
            chk_word(RDATA, rows[i].q);
        end
        creg(1'b1, 1'b1, 1'b0, 12'hc04, 32'h20000101);
        acc(1'b1, 2'h0, 3'h2, 32'h20000000, 32'hffffffff);
        chk_resp(3'h4);
        acc(1'b0, 2'h0, 3'h2, 32'h20000000, 32'h0);
        chk_word(RDATA, 32'h11223344);
        for (int s = 0; s < 5; s++) begin
            creg(1'b1, 1'b1, 1'b0, 12'hc04, 32'h20000001 | (2 << s));
            acc(1'b0, 2'h0, 3'(s), 32'h20000000, 32'h0);
            chk_resp(3'h2);
            acc(1'b0, 2'h0, 3'((s + 1) % 5), 32'h20000000, 32'h0);
            chk_resp(3'h1);
        end
        creg(1'b1, 1'b1, 1'b0, 12'hc04, 32'h20000015);
        acc(1'b0, 2'h0, 3'h1, 32'h20000000, 32'h0);
        chk_resp(3'h2);
        acc(1'b0, 2'h0, 3'h2, 32'h20000000, 32'h0);
        chk_resp(3'h1);
        @(posedge CLOCK);
        NRST <= 1'b0;
        repeat (2) @(posedge CLOCK);
        NRST <= 1'b1;
        acc(1'b0, 2'h0, 3'h2, 32'h20000000, 32'h0);
        chk_resp(3'h2);
        final_report();
    end
endmodule

/* File: hw/lsbd_map.svh */
// Register layout, control codes and size constants for the local SRAM decode.
`ifndef LSBD_MAP_SVH
`define LSBD_MAP_SVH
`define LSBD_CREG_SRAM_BASE 12'hc04
`define LSBD_BIT_VALID 0
`define LSBD_BIT_UD 1
`define LSBD_BIT_UC 2
`define LSBD_BIT_SD 3
`define LSBD_BIT_SC 4
`define LSBD_BIT_CI 5
`define LSBD_BIT_WP 8
`define LSBD_BASE_LSB 9
`define LSBD_IMPL_MASK 32'hffffff3f
`define LSBD_SIZE_LONG 2'h0
`define LSBD_SIZE_BYTE 2'h1
`define LSBD_SIZE_WORD 2'h2
`define LSBD_SPACE_UD 3'h0
`define LSBD_SPACE_UC 3'h1
`define LSBD_SPACE_SD 3'h2
`define LSBD_SPACE_SC 3'h3
`define LSBD_SPACE_CI 3'h4
`endif

/* File: hw/lsbd_pkg.sv */
// Types shared by the local SRAM decode files.
package lsbd_pkg;
    typedef enum logic [1:0] {
        LSBD_IDLE = 2'b00,
        LSBD_DONE = 2'b01,
        LSBD_EXT = 2'b10,
        LSBD_ERR = 2'b11
    } lsbd_resp_t;
endpackage

/* File: hw/lsbd_ram.sv */
// Single-cycle 128 x 32 SRAM array with byte write enables.
`timescale 1ns/1ps
module lsbd_ram #(
    parameter int WORDS = 128,
    parameter int AW = 7
) (
    input wire logic clk, // Processor clock.
    input wire logic en, // Array enable.
    input wire logic we, // Write strobe.
    input wire logic [AW-1:0] addr, // Word index.
    input wire logic [3:0] be, // Byte lane enables.
    input wire logic [31:0] wdata, // Write data.
    output logic [31:0] rdata // Read data, same cycle; zero when idle.
);
    logic [31:0] mem [WORDS];

    // The word is only driven out while the array is enabled for a read.
    always_comb begin
        rdata = 32'h0;
        if (en && !we) begin
            rdata = mem[addr];
        end
    end

    // Contents are not reset; they hold whatever they had until written.
    genvar g;
    for (g = 0; g < 4; g++) begin : g_lane
        always_ff @(posedge clk) begin
            if (en && we && be[g]) begin
                mem[addr][g*8 +: 8] <= wdata[g*8 +: 8];
            end
        end
    end

endmodule

/* File: hw/lsbd_top.sv */
// Local SRAM base decode: control register, hit logic and SRAM access.
`timescale 1ns/1ps
`include "lsbd_map.svh"
module lsbd_top #(
    parameter int WORDS = 128,
    parameter int AW = 7
) (
    input wire logic CLOCK, // Processor clock, 40 MHz.
    input wire logic NRST, // Asynchronous reset, active low.
    input wire logic REQ, // Local bus access request, one cycle.
    input wire logic [31:0] ADDR, // Byte address.
    input wire logic WRITE, // One for a write.
    input wire logic [1:0] SIZE, // 0 long, 1 byte, 2 word.
    input wire logic [2:0] SPACE, // Address space code.
    input wire logic [31:0] WDATA, // Write data, lane aligned.
    input wire logic CREG_WR, // Control register move strobe.
    input wire logic CREG_RD, // Control register read strobe.
    input wire logic [11:0] CREG_CODE, // Control register code.
    input wire logic [31:0] CREG_WDATA, // Control register write data.
    input wire logic SUPERVISOR, // Requester is in supervisor mode.
    input wire logic DEBUG_STATE, // Background debug state.
    input wire logic [31:0] ICACHE_DATA, // Instruction cache result.
    output logic [31:0] CREG_RDATA, // Control register read data.
    output logic RESP_DONE, // SRAM access completed.
    output logic RESP_EXT, // Access goes to the external bus.
    output logic RESP_ERR, // Write-protect access error.
    output logic [31:0] RDATA, // Read data to the requester.
    output logic CACHE_FILL_INH // Keep returned data out of the cache.
);
    lsbd_pkg::lsbd_resp_t resp_next;
    logic done_reg, ext_reg, err_reg;
    logic [31:0] rdata_reg, rdata_next;
    logic [31:0] base_cfg_reg, base_cfg_next;
    logic valid_reg, valid_next;
    logic [31:0] creg_rdata_reg, creg_rdata_next;
    logic cache_inh_reg, cache_inh_next;
    logic [31:0] ram_rdata;
    logic [31:0] sram_base_config;
    logic space_masked, addr_match, hit, space_idle, is_fetch;
    logic ram_en, ram_we;
    logic [3:0] be;
    logic creg_sel;

    // ==========================================================
    // Decode
    assign sram_base_config = {base_cfg_reg[31:1], valid_reg};
    assign creg_sel = (CREG_CODE == `LSBD_CREG_SRAM_BASE);
    assign is_fetch = (SPACE == `LSBD_SPACE_UC) ||
                      (SPACE == `LSBD_SPACE_SC);

    always_comb begin
        space_masked = 1'b1;
        case (SPACE)
            `LSBD_SPACE_UD: space_masked = sram_base_config[`LSBD_BIT_UD];
            `LSBD_SPACE_UC: space_masked = sram_base_config[`LSBD_BIT_UC];
            `LSBD_SPACE_SD: space_masked = sram_base_config[`LSBD_BIT_SD];
            `LSBD_SPACE_SC: space_masked = sram_base_config[`LSBD_BIT_SC];
            `LSBD_SPACE_CI: space_masked = sram_base_config[`LSBD_BIT_CI];
            default: space_masked = 1'b1;
        endcase
    end

    // Power saving: a class of access whose both masks are set never
    // enables the array, even for a stray match.
    always_comb begin
        if (is_fetch) begin
            space_idle = sram_base_config[`LSBD_BIT_SC] &&
                         sram_base_config[`LSBD_BIT_UC];
        end else begin
            space_idle = sram_base_config[`LSBD_BIT_SD] &&
                         sram_base_config[`LSBD_BIT_UD];
        end
    end

    assign addr_match = (ADDR[31:`LSBD_BASE_LSB] ==
                         sram_base_config[31:`LSBD_BASE_LSB]);
    assign hit = sram_base_config[`LSBD_BIT_VALID] && addr_match &&
                 !space_masked && !space_idle;
    // Core and debug requests share this port.
    assign ram_en = REQ && hit &&
                    !(WRITE && sram_base_config[`LSBD_BIT_WP]);
    assign ram_we = WRITE;

    always_comb begin
        be = 4'h0;
        case (SIZE)
            `LSBD_SIZE_LONG: be = 4'hf;
            `LSBD_SIZE_WORD: be = ADDR[1] ? 4'h3 : 4'hc;
            `LSBD_SIZE_BYTE: be = 4'h8 >> ADDR[1:0];
            default: be = 4'h0;
        endcase
    end

    // ==========================================================
    // SRAM array
    // Array is not cleared at reset.
    lsbd_ram #(
        .WORDS(WORDS),
        .AW(AW)
    ) u_ram (
        .clk(CLOCK),
        .en(ram_en),
        .we(ram_we),
        .addr(ADDR[AW+1:2]),
        .be(be),
        .wdata(WDATA),
        .rdata(ram_rdata)
    );

    // ==========================================================
    // Base register
    always_comb begin
        base_cfg_next = base_cfg_reg;
        valid_next = valid_reg;
        creg_rdata_next = 32'h0;
        if (CREG_WR && creg_sel && (SUPERVISOR || DEBUG_STATE)) begin
            base_cfg_next = CREG_WDATA & `LSBD_IMPL_MASK;
            valid_next = CREG_WDATA[`LSBD_BIT_VALID];
        end
        // Only background debug sees the value; software reads zero.
        if (CREG_RD && creg_sel && DEBUG_STATE) begin
            creg_rdata_next = sram_base_config & `LSBD_IMPL_MASK;
        end
        // No read-only register exists here, so no write lands elsewhere.
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            valid_reg <= 1'b0;
            creg_rdata_reg <= 32'h0;
        end else begin
            valid_reg <= valid_next;
            creg_rdata_reg <= creg_rdata_next;
        end
    end

    // The remaining fields are left uninitialised at reset.
    always_ff @(posedge CLOCK) begin
        base_cfg_reg <= base_cfg_next;
    end

    // ==========================================================
    // Response
    always_comb begin
        resp_next = lsbd_pkg::LSBD_IDLE;
        rdata_next = 32'h0;
        cache_inh_next = 1'b0;
        if (REQ) begin
            if (!hit) begin
                resp_next = lsbd_pkg::LSBD_EXT;
                // A fetch outside the SRAM keeps the cache result.
                if (is_fetch && !WRITE) begin
                    rdata_next = ICACHE_DATA;
                end
            end else if (WRITE && sram_base_config[`LSBD_BIT_WP]) begin
                resp_next = lsbd_pkg::LSBD_ERR;
            end else begin
                resp_next = lsbd_pkg::LSBD_DONE;
                // SRAM data replaces the cache result on a hit.
                if (!WRITE) begin
                    rdata_next = ram_rdata;
                end
                cache_inh_next = !WRITE;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            done_reg <= 1'b0;
            ext_reg <= 1'b0;
            err_reg <= 1'b0;
            rdata_reg <= 32'h0;
            cache_inh_reg <= 1'b0;
        end else begin
            done_reg <= (resp_next == lsbd_pkg::LSBD_DONE);
            ext_reg <= (resp_next == lsbd_pkg::LSBD_EXT);
            err_reg <= (resp_next == lsbd_pkg::LSBD_ERR);
            rdata_reg <= rdata_next;
            cache_inh_reg <= cache_inh_next;
        end
    end

    assign RESP_DONE = done_reg;
    assign RESP_EXT = ext_reg;
    assign RESP_ERR = err_reg;
    assign CREG_RDATA = creg_rdata_reg;
    assign CACHE_FILL_INH = cache_inh_reg;
    assign RDATA = rdata_reg;
endmodule
